/* File: src/flbc_top.sv */
// Fault lamp controller: bulb check, fault warning and trouble code readout
`timescale 1ns/10ps
// Summary of operation
// - Normal mode, ignition on, engine stopped: lamp steadily on as bulb check.
// - When the engine starts the lamp goes off unless a fault keeps it lit.
// - Engine running: lamp on while a fault or processor failure is present.
// - Readout mode, entered with engine stopped, blinks out each stored code not yet hidden.
// - Long 0.6 s blinks count the left value, then short 0.3 s the right.
// - With nothing stored the readout shows code 0505.
// - Going from readout back to normal mode clears all stored codes.
// - A fault seen for the first time is stored and lights the lamp.
// - Same fault in two consecutive qualifying patterns latches the lamp on.
// - Three consecutive clean qualifying patterns turn a latched lamp off.
// - After 40 clean patterns a code is no longer shown but stays stored.
module flbc_top #(
	parameter int NUM_FAULTS  = 8,
	parameter int TICK_CYCLES = flbc_pkg::TICK_CYCLES
) (
	input  wire logic                                   clk,
	input  wire logic                                   resetn,
	input  wire flbc_pkg::flbc_vehicle_t                vehicle,
	input  wire logic [NUM_FAULTS-1:0]                  faultDetect,
	input  wire flbc_pkg::flbc_code_t [NUM_FAULTS-1:0]  faultCodes,
	output logic                                        faultLamp,
	output logic                                        readoutActive,
	output logic                                        lampLatched,
	output logic [NUM_FAULTS-1:0]                       codeStored
);
	import flbc_pkg::*;

	localparam int IW = (NUM_FAULTS > 1) ? $clog2(NUM_FAULTS) : 1;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	// Fault memory survives ignition cycles; only reset or a readout exit clears it.
	// The shown set is a subset of stored: a code may be hidden yet still held.
	// Clean counters saturate, so a code hidden long ago does not wrap back into view.
	typedef struct packed {
		logic                       readout;
		logic [IW-1:0]              showIdx;
		logic [NUM_FAULTS-1:0]      stored;
		logic [NUM_FAULTS-1:0]      shown;
		logic [NUM_FAULTS-1:0]      seen;      // Fault met in the current pattern
		logic [NUM_FAULTS-1:0]      prevSeen;  // Fault met in the last qualifying one
		logic [NUM_FAULTS-1:0][5:0] cleanCnt;
		logic [1:0]                 cleanRun;
		logic                       latched;
		logic                       patternLit;
		logic                       lamp;
	} flbc_state_t;

	// Working copies of the state record and the glue around the sequencer
	flbc_state_t q;
	flbc_state_t d;
	flbc_code_t  showCode;
	logic        blinkLamp;
	logic        codeDone;
	logic        anyDetect;
	logic        anySeen;
	logic        repeatSeen;

	// Every output is a plain register bit of the state record
	assign faultLamp     = q.lamp;
	assign readoutActive = q.readout;
	assign lampLatched   = q.latched;
	assign codeStored    = q.stored;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Next shown slot after idx, wrapping; returns idx itself when none other
	// Scans one full turn, so a lone shown slot is found again from itself;
	// the loop bound is a parameter, which keeps the logic a fixed mux tree
	function automatic logic [IW-1:0] nextShown(input logic [NUM_FAULTS-1:0] shownSet,
		input logic [IW-1:0] idx);
		logic [IW-1:0] res;
		logic          found;
		int            k;
		res = idx;
		found = 1'b0;
		for (int j = 1; j <= NUM_FAULTS; j++) begin
			k = (int'(idx) + j) % NUM_FAULTS;
			if (!found && shownSet[k]) begin
				res = IW'(k);
				found = 1'b1;
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Code selection and blink sequencer
	// ----------------------------------------------------------------
	// A slot that is not shown means the whole list is empty
	// The sequencer takes the code only when it starts a new one, so a change
	// of the shown set in mid code never garbles a blink that is running
	always_comb begin
		if (q.shown[q.showIdx]) begin
			showCode = faultCodes[q.showIdx];
		end else begin
			showCode = NO_FAULT_CODE;
		end
	end

	// Sequencer runs only in readout; leaving drops it back to idle at once
	flbc_blink_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_blink (
		.clk     (clk),
		.resetn  (resetn),
		.enable  (q.readout),
		.code    (showCode),
		.lamp    (blinkLamp),
		.codeDone(codeDone)
	);

	// ----------------------------------------------------------------
	// Mode, fault memory and drive cycle counters
	// ----------------------------------------------------------------
	// Order matters: clear first, pattern close next, new detections last,
	// so a detection in the clearing cycle survives
	always_comb begin
		d = q;
		anyDetect = |faultDetect;
		anySeen = |q.seen;
		repeatSeen = |(q.seen & q.prevSeen);

		// Mode switching
		// Entry needs the engine stopped; a start during readout keeps the mode.
		// Exit clears the codes; the latch and its clean run are not codes and stay.
		if (!q.readout) begin
			if (vehicle.readoutRequest && vehicle.ignitionOn && !vehicle.engineRunning) begin
				d.readout = 1'b1;
				d.showIdx = nextShown(q.shown, IW'(NUM_FAULTS - 1));
			end
		end else if (!vehicle.readoutRequest) begin
			d.readout = 1'b0;
			d.stored = '0;
			d.shown = '0;
			d.prevSeen = '0;
			d.cleanCnt = '0;
		end else if (codeDone) begin
			d.showIdx = nextShown(q.shown, q.showIdx);
		end

		// Close of a driving pattern
		// A pattern that fails the diagnostic condition only closes the pattern,
		// so it can neither latch, unlatch nor hide anything
		if (vehicle.patternEnd) begin
			d.seen = '0;
			d.patternLit = 1'b0;
			if (vehicle.patternQualifies) begin
				for (int i = 0; i < NUM_FAULTS; i++) begin
					if (q.seen[i]) begin
						d.prevSeen[i] = 1'b1;
						d.cleanCnt[i] = '0;
					end else begin
						d.prevSeen[i] = 1'b0;
						if (q.cleanCnt[i] != HIDE_PATTERNS) begin
							d.cleanCnt[i] = q.cleanCnt[i] + 6'h01;
						end
						if (q.cleanCnt[i] + 6'h01 >= HIDE_PATTERNS) begin
							d.shown[i] = 1'b0;
						end
					end
				end
				if (repeatSeen) begin
					d.latched = 1'b1;
					d.cleanRun = '0;
				end else if (anySeen) begin
					d.cleanRun = '0;
				end else begin
					if (q.cleanRun != UNLATCH_PATTERNS) begin
						d.cleanRun = q.cleanRun + 2'h1;
					end
					if (q.cleanRun + 2'h1 >= UNLATCH_PATTERNS) begin
						d.latched = 1'b0;
					end
				end
			end
		end

		// New detections win over any clear in the same cycle
		// A hidden code that comes back is shown again from the next pass of the list
		for (int i = 0; i < NUM_FAULTS; i++) begin
			if (faultDetect[i]) begin
				d.stored[i] = 1'b1;
				d.shown[i] = 1'b1;
				d.seen[i] = 1'b1;
				d.cleanCnt[i] = '0;
			end
		end
		if (anyDetect) begin
			d.patternLit = 1'b1;
		end

		// Lamp drive
		// Readout owns the lamp; below it ignition off, bulb check, then warning
		if (q.readout) begin
			d.lamp = blinkLamp;
		end else if (!vehicle.ignitionOn) begin
			d.lamp = 1'b0;
		end else if (!vehicle.engineRunning) begin
			d.lamp = 1'b1;
		end else begin
			// Fault warning, or the lamp kept lit by a latched or fresh fault
			d.lamp = anyDetect || vehicle.cpuFault || q.patternLit || q.latched;
		end
	end

	// State register; memory is not cleared by ignition, only by reset or a readout exit
	// The asynchronous branch loads constants only; run-time values come from d
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

/* File: src/flbc_pkg.sv */
// Shared constants and types of the fault lamp blink code logic
package flbc_pkg;

	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 25_000_000;
	localparam int TICK_MS     = 100;                     // Blink time base step
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS; // Cycles per step

	// ----------------------------------------------------------------
	// Blink timing, in ms as specified, then in time base steps
	// ----------------------------------------------------------------
	localparam int LONG_ON_MS   = 600;
	localparam int SHORT_ON_MS  = 300;
	localparam int BLINK_GAP_MS = 300;
	localparam int GROUP_GAP_MS = 1000;
	localparam int CODE_GAP_MS  = 2000;
	localparam logic [4:0] LONG_ON_TICKS   = 5'(LONG_ON_MS / TICK_MS);
	localparam logic [4:0] SHORT_ON_TICKS  = 5'(SHORT_ON_MS / TICK_MS);
	localparam logic [4:0] BLINK_GAP_TICKS = 5'(BLINK_GAP_MS / TICK_MS);
	localparam logic [4:0] GROUP_GAP_TICKS = 5'(GROUP_GAP_MS / TICK_MS);
	localparam logic [4:0] CODE_GAP_TICKS  = 5'(CODE_GAP_MS / TICK_MS);
	localparam logic [4:0] TIMER_LAST      = 5'h01;

	// ----------------------------------------------------------------
	// Drive cycle thresholds
	// ----------------------------------------------------------------
	localparam logic [1:0] UNLATCH_PATTERNS = 2'h3; // Clean patterns to unlatch
	localparam logic [5:0] HIDE_PATTERNS    = 6'h28; // Clean patterns to hide code

	// ----------------------------------------------------------------
	// Trouble codes
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] leftVal;  // Counted by long blinks
		logic [7:0] rightVal; // Counted by short blinks
	} flbc_code_t;

	localparam flbc_code_t NO_FAULT_CODE = '{leftVal: 8'h05, rightVal: 8'h05};

	// Vehicle state seen by the lamp logic
	typedef struct packed {
		logic ignitionOn;
		logic engineRunning;
		logic cpuFault;
		logic readoutRequest;   // Mode select level from the service connector
		logic patternEnd;       // One-cycle pulse at the end of a driving pattern
		logic patternQualifies; // Pattern met the self-diagnostic condition
	} flbc_vehicle_t;

	// Blink sequencer states
	typedef enum logic [6:0] {
		BL_IDLE      = 7'h01,
		BL_LONG_ON   = 7'h02,
		BL_LONG_OFF  = 7'h04,
		BL_GROUP_GAP = 7'h08,
		BL_SHORT_ON  = 7'h10,
		BL_SHORT_OFF = 7'h20,
		BL_CODE_GAP  = 7'h40
	} flbc_blink_e;

endpackage

/* File: src/flbc_blink_gen.sv */
// Blink sequencer: shows one trouble code as long and short lamp pulses
`timescale 1ns/10ps
module flbc_blink_gen #(
	parameter int TICK_CYCLES = flbc_pkg::TICK_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                enable,
	input  wire flbc_pkg::flbc_code_t code,
	output logic                     lamp,
	output logic                     codeDone
);
	import flbc_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	typedef struct packed {
		flbc_blink_e   state;
		logic [TW-1:0] tickCnt;
		logic [4:0]    timer;
		logic [7:0]    remain;
		logic [7:0]    rightVal;
		logic          lamp;
		logic          codeDone;
	} flbc_gen_t;

	flbc_gen_t q;
	flbc_gen_t d;
	logic      tick;
	logic      expire;

	assign lamp     = q.lamp;
	assign codeDone = q.codeDone;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Time base restarts with each code so the first blink has full length
	always_comb begin
		d = q;
		d.codeDone = 1'b0;
		tick = (q.tickCnt == TICK_LAST);
		expire = tick && (q.timer == TIMER_LAST);
		d.tickCnt = tick ? '0 : q.tickCnt + 1'b1;
		if (tick) begin
			d.timer = q.timer - 1'b1;
		end
		case (q.state)
			BL_IDLE: begin
				d.tickCnt = '0;
				d.rightVal = code.rightVal;
				// Wait out the done cycle so the owner has moved on to the next code
				if (!enable || q.codeDone) begin
					d.state = BL_IDLE;
				end else if (code.leftVal != 8'h00) begin
					d.state = BL_LONG_ON;
					d.timer = LONG_ON_TICKS;
					d.remain = code.leftVal;
				end else if (code.rightVal != 8'h00) begin
					d.state = BL_SHORT_ON;
					d.timer = SHORT_ON_TICKS;
					d.remain = code.rightVal;
				end else begin
					d.state = BL_CODE_GAP;
					d.timer = CODE_GAP_TICKS;
				end
			end
			BL_LONG_ON: begin
				if (expire) begin
					d.remain = q.remain - 1'b1;
					if (q.remain != 8'h01) begin
						d.state = BL_LONG_OFF;
						d.timer = BLINK_GAP_TICKS;
					end else if (q.rightVal != 8'h00) begin
						d.state = BL_GROUP_GAP;
						d.timer = GROUP_GAP_TICKS;
					end else begin
						d.state = BL_CODE_GAP;
						d.timer = CODE_GAP_TICKS;
					end
				end
			end
			BL_LONG_OFF: begin
				if (expire) begin
					d.state = BL_LONG_ON;
					d.timer = LONG_ON_TICKS;
				end
			end
			BL_GROUP_GAP: begin
				if (expire) begin
					d.state = BL_SHORT_ON;
					d.timer = SHORT_ON_TICKS;
					d.remain = q.rightVal;
				end
			end
			BL_SHORT_ON: begin
				if (expire) begin
					d.remain = q.remain - 1'b1;
					if (q.remain != 8'h01) begin
						d.state = BL_SHORT_OFF;
						d.timer = BLINK_GAP_TICKS;
					end else begin
						d.state = BL_CODE_GAP;
						d.timer = CODE_GAP_TICKS;
					end
				end
			end
			BL_SHORT_OFF: begin
				if (expire) begin
					d.state = BL_SHORT_ON;
					d.timer = SHORT_ON_TICKS;
				end
			end
			BL_CODE_GAP: begin
				if (expire) begin
					d.state = BL_IDLE;
					d.codeDone = 1'b1;
				end
			end
			default: begin
				d.state = BL_IDLE;
			end
		endcase
		// Leaving readout drops the lamp at once, mid blink if need be
		if (!enable) begin
			d.state = BL_IDLE;
			d.codeDone = 1'b0;
		end
		d.lamp = (d.state == BL_LONG_ON) || (d.state == BL_SHORT_ON);
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{state: BL_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

endmodule

/* File: test/flbc_monitor.sv */
// Port checker for the fault lamp controller
`timescale 1ns/10ps
module flbc_monitor #(
	parameter int NUM_FAULTS  = 8,
	parameter int TICK_CYCLES = 4
) (
	input wire logic                                  clk,
	input wire logic                                  resetn,
	input wire flbc_pkg::flbc_vehicle_t               vehicle,
	input wire logic [NUM_FAULTS-1:0]                 faultDetect,
	input wire flbc_pkg::flbc_code_t [NUM_FAULTS-1:0] faultCodes,
	input wire logic                                  faultLamp,
	input wire logic                                  readoutActive,
	input wire logic                                  lampLatched,
	input wire logic [NUM_FAULTS-1:0]                 codeStored
);
	import flbc_pkg::*;
	logic [31:0] onCnt_q;

	// Lamp-on run length in readout; a run is judged on the cycle it ends
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			onCnt_q <= '0;
		end else begin
			onCnt_q <= (faultLamp && readoutActive) ? onCnt_q + 32'h1 : '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------------
	// Mode change steps
	// ----------------------------------------------------------------
	sequence s_entry;
		!readoutActive && vehicle.readoutRequest && vehicle.ignitionOn && !vehicle.engineRunning;
	endsequence
	sequence s_exit;
		readoutActive && !vehicle.readoutRequest;
	endsequence

	a_bulb_check: assert property (!readoutActive && vehicle.ignitionOn &&
		!vehicle.engineRunning |=> faultLamp) else $error("bulb check lamp dark");
	a_clean_dark: assert property (!readoutActive && vehicle.ignitionOn &&
		vehicle.engineRunning && !vehicle.cpuFault && faultDetect == '0 && !lampLatched &&
		codeStored == '0 |=> !faultLamp) else $error("lamp lit without fault");
	a_fault_warn: assert property (!readoutActive && vehicle.ignitionOn &&
		vehicle.engineRunning && (vehicle.cpuFault || faultDetect != '0) |=> faultLamp)
		else $error("fault not shown");
	a_readout_entry: assert property (s_entry |=> readoutActive)
		else $error("readout not entered");
	a_readout_hold: assert property (readoutActive && vehicle.readoutRequest
		|=> readoutActive) else $error("readout left early");
	a_blink_length: assert property (readoutActive && $past(readoutActive, 3) &&
		$fell(faultLamp) |-> onCnt_q == LONG_ON_TICKS * TICK_CYCLES ||
		onCnt_q == SHORT_ON_TICKS * TICK_CYCLES) else $error("blink length wrong");
	a_first_store: assert property (faultDetect != '0 |=>
		(codeStored & $past(faultDetect)) == $past(faultDetect)) else $error("code not stored");
	a_exit_clear: assert property (s_exit |=> !readoutActive &&
		(codeStored & ~$past(faultDetect)) == '0) else $error("codes kept on exit");
	a_latch_cause: assert property ($changed(lampLatched) |->
		$past(vehicle.patternEnd && vehicle.patternQualifies)) else $error("latch moved alone");
endmodule

bind flbc_top flbc_monitor #(.NUM_FAULTS(NUM_FAULTS), .TICK_CYCLES(TICK_CYCLES)) u_mon (
	.clk(clk), .resetn(resetn), .vehicle(vehicle), .faultDetect(faultDetect),
	.faultCodes(faultCodes), .faultLamp(faultLamp), .readoutActive(readoutActive),
	.lampLatched(lampLatched), .codeStored(codeStored));

/* File: test/flbc_lamp_reader.sv */
// Technician model: counts long and short lamp blinks into codes
`timescale 1ns/10ps
module flbc_lamp_reader #(
	parameter int TICK_CYCLES = 4
) (
	input  wire logic           clk,
	input  wire logic           resetn,
	input  wire logic           lamp,
	input  wire logic           active,
	output flbc_pkg::flbc_code_t codeSeen,
	output logic                codeValid,
	output logic                badPulse
);
	import flbc_pkg::*;
	flbc_code_t acc;
	int         onCnt;
	int         offCnt;
	logic       armed;

	// Arm on the first dark cycle, so the bulb check is not read as a blink
	always @(posedge clk) begin
		codeValid <= 1'b0;
		badPulse <= 1'b0;
		if (!resetn || !active) begin
			onCnt <= 0;
			offCnt <= 0;
			armed <= 1'b0;
			acc <= '0;
		end else if (!armed) begin
			armed <= !lamp;
		end else if (lamp) begin
			onCnt <= onCnt + 1;
			offCnt <= 0;
		end else begin
			offCnt <= offCnt + 1;
			onCnt <= 0;
			if (onCnt == LONG_ON_TICKS * TICK_CYCLES) begin
				acc.leftVal <= acc.leftVal + 8'h01;
			end else if (onCnt == SHORT_ON_TICKS * TICK_CYCLES) begin
				acc.rightVal <= acc.rightVal + 8'h01;
			end else if (onCnt != 0) begin
				badPulse <= 1'b1;
			end
			// Group gap is shorter than this, code gap longer
			if (offCnt == 15 * TICK_CYCLES && acc != '0) begin
				codeValid <= 1'b1;
				codeSeen <= acc;
				acc <= '0;
			end
		end
	end
endmodule

/* File: test/flbc_tb_top.sv */
// Self-checking bench for the fault lamp controller
`timescale 1ns/10ps
module flbc_tb_top;
	import flbc_pkg::*;
	localparam int NF = 2;
	localparam int TC = 4;
	logic                clk;
	logic                resetn;
	logic                faultLamp;
	logic                readoutActive;
	logic                lampLatched;
	logic                codeValid;
	logic                badPulse;
	logic [NF-1:0]       faultDetect;
	logic [NF-1:0]       codeStored;
	flbc_vehicle_t       vehicle;
	flbc_code_t [NF-1:0] faultCodes;
	flbc_code_t          codeSeen;
	flbc_code_t          expQ[$];
	int                  errors;
	int                  cmp_count;
	int                  seed;
	int                  i;

	flbc_top #(.NUM_FAULTS(NF), .TICK_CYCLES(TC)) DUT (.clk(clk), .resetn(resetn),
		.vehicle(vehicle), .faultDetect(faultDetect), .faultCodes(faultCodes),
		.faultLamp(faultLamp), .readoutActive(readoutActive), .lampLatched(lampLatched),
		.codeStored(codeStored));
	flbc_lamp_reader #(.TICK_CYCLES(TC)) u_reader (.clk(clk), .resetn(resetn),
		.lamp(faultLamp), .active(readoutActive), .codeSeen(codeSeen),
		.codeValid(codeValid), .badPulse(badPulse));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Inputs set at one rising edge are taken at the next; read at the falling edge after it
	task automatic look(input int sel, input logic [15:0] e);
		logic [15:0] o[4];
		@(posedge clk);
		@(negedge clk);
		o = '{16'(faultLamp), 16'(readoutActive), 16'(lampLatched), 16'(codeStored)};
		chk(o[sel], e);
		@(posedge clk);
	endtask

	task automatic pattern(input logic q);
		@(posedge clk);
		vehicle.patternEnd <= 1'b1;
		vehicle.patternQualifies <= q;
		@(posedge clk);
		vehicle.patternEnd <= 1'b0;
	endtask

	task automatic detect(input int s);
		@(posedge clk);
		faultDetect <= NF'(1) << s;
		@(posedge clk);
		faultDetect <= '0;
	endtask

	// Stay in readout until every queued code was read, then leave
	task automatic readout();
		int n;
		@(posedge clk);
		vehicle.readoutRequest <= 1'b1;
		for (n = 0; n < 5000 && expQ.size() > 0; n++) begin
			@(posedge clk);
		end
		// A hang counts once; the run goes on to the closing report
		if (expQ.size() > 0) begin
			errors++;
			$display("[ERR] %0t readout timed out", $time);
			expQ.delete();
		end
		vehicle.readoutRequest <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// Each decoded code takes the oldest expectation off the queue
	always @(posedge clk) begin
		if (codeValid === 1'b1 && expQ.size() == 0) begin
			errors++;
			$display("[ERR] %0t unexpected code", $time);
		end else if (codeValid === 1'b1) begin
			chk(codeSeen, expQ.pop_front());
		end
		if (badPulse === 1'b1) begin
			errors++;
			$display("[ERR] %0t bad blink", $time);
		end
	end

	initial begin
		seed = 54290;
		errors = 0;
		cmp_count = 0;
		vehicle = '0;
		faultDetect = '0;
		resetn = 1'b0;
		// Zero right values skip the short group
		for (i = 0; i < NF; i++) begin
			faultCodes[i].leftVal = 8'(1 + {$random(seed)} % 3);
			faultCodes[i].rightVal = 8'({$random(seed)} % 3);
		end
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		look(3, 16'h0);
		vehicle.ignitionOn <= 1'b1;
		look(0, 16'h1);
		vehicle.engineRunning <= 1'b1;
		vehicle.readoutRequest <= 1'b1;
		look(0, 16'h0);
		look(1, 16'h0);
		vehicle.readoutRequest <= 1'b0;
		look(0, 16'h0);
		vehicle.cpuFault <= 1'b1;
		look(0, 16'h1);
		vehicle.cpuFault <= 1'b0;
		vehicle.engineRunning <= 1'b0;
		$display("test lamp modes done");
		expQ = '{NO_FAULT_CODE, NO_FAULT_CODE};
		readout();
		$display("test empty readout done");
		detect(1);
		detect(0);
		look(3, 16'h3);
		expQ = '{faultCodes[0], faultCodes[1], faultCodes[0]};
		readout();
		look(3, 16'h0);
		pattern(1'b0);
		$display("test code readout done");
		detect(1);
		pattern(1'b1);
		repeat (40) pattern(1'b1);
		look(3, 16'h2);
		expQ = '{NO_FAULT_CODE};
		readout();
		$display("test code hiding done");
		// Engine running, so the lamp shows the fresh fault and then the latch
		vehicle.engineRunning <= 1'b1;
		for (i = 0; i < 2; i++) begin
			detect(0);
			look(0, 16'h1);
			pattern(1'b1);
		end
		look(2, 16'h1);
		look(0, 16'h1);
		vehicle.engineRunning <= 1'b0;
		repeat (3) pattern(1'b0);
		repeat (2) pattern(1'b1);
		look(2, 16'h1);
		pattern(1'b1);
		look(2, 16'h0);
		$display("test lamp latch done");
		final_report();
	end
endmodule
